//--- rtl/hmo_pkg.sv
// Package: register map, field positions and shared types of the monitor
package hmo_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CPU_OFFSET = 8'h55;
   localparam logic [7:0] IDX_AUX_OFFSET = 8'h56;
   localparam logic [7:0] IDX_STATUS_A = 8'h59;
   localparam logic [7:0] IDX_STATUS_B = 8'h5a;
   localparam logic [7:0] IDX_EVT_STATUS = 8'h60;
   localparam logic [7:0] IDX_EVT_MASK = 8'h61;
   localparam int ADDR_W = 10;
   localparam int IDX_LSB = 2;
   // Reset values
   localparam logic [7:0] OFFSET_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [15:0] EVT_RST = 16'h0000;
   // Status A fields
   localparam int SA_CPU_FAN0 = 7;
   localparam int SA_SYS_FAN = 6;
   localparam int SA_CPU_TEMP = 5;
   localparam int SA_SYS_TEMP = 4;
   localparam int SA_VOLT_HI = 3;
   // Status B fields
   localparam int SB_CPU_FAN0_WARN = 7;
   localparam int SB_SYS_FAN_WARN = 6;
   localparam int SB_AUX_TEMP = 5;
   localparam int SB_INTRUSION = 4;
   localparam int SB_AUX_FAN0 = 3;
   localparam int SB_CPU_FAN1 = 2;
   localparam int SB_CPU_FAN1_WARN = 1;
   localparam int SB_AIN1 = 0;
   // Index into fan and warning vectors
   localparam int FAN_CPU0 = 0;
   localparam int FAN_SYS = 1;
   localparam int FAN_AUX0 = 2;
   localparam int FAN_CPU1 = 3;
   localparam int WARN_SYS = 0;
   localparam int WARN_CPU0 = 1;
   localparam int WARN_CPU1 = 2;
   localparam int NUM_WARN = 3;
   // Avalon response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Target warning dwell: three minutes
   localparam longint unsigned WARN_TIME_S = 180;
   localparam longint unsigned CLK_HZ = 50000000;
   localparam longint unsigned WARN_CYCLES = WARN_TIME_S * CLK_HZ;
   localparam int WARN_CNT_W = 34;
   // Saturation limits of a signed 8-bit reading
   localparam logic [7:0] TEMP_MAX = 8'h7f;
   localparam logic [7:0] TEMP_MIN = 8'h80;

   // Limit pair of one temperature channel
   typedef struct packed {
      logic [7:0] over;
      logic [7:0] hyst;
   } hmo_temp_lim_s;

   // Fan-control state of one automatic target-temperature loop
   typedef struct packed {
      logic auto_mode;
      logic full_speed;
      logic over_target;
   } hmo_fan_ctl_s;
endpackage : hmo_pkg

//--- rtl/hmo_monitor_status.sv
// Module: temperature offsets, live status flags and register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] CPU temperature reading is monitored value plus CPU offset register.
// [RQ2] Auxiliary temperature reading is monitored value plus auxiliary offset.
// [RQ3] Status A bits 7, 6 show CPU fan 0 and system fan over count.
// [RQ4] Status B bits 3, 2 show auxiliary fan 0 and CPU fan 1 count.
// [RQ5] Temperature flags set when reading exceeds its over-temperature limit.
// [RQ6] Temperature flags clear once reading falls below hysteresis limit.
// [RQ7] Status A bits 3..0 flag out-of-window voltage inputs.
// [RQ8] Status B bit 0 flags analog input one out of window.
// [RQ9] Status B bit 4 shows a latched chassis intrusion.
// [RQ10] Status B bit 6 warns system fan loop over target three minutes.
// [RQ11] Status B bit 7 warns CPU fan 0 loop over target three minutes.
// [RQ12] Status B bit 1 warns CPU fan 1 loop over target three minutes.
// [RQ13] Both status registers are 8-bit read-only; writes change nothing.
// [RQ14] Flags refresh after each conversion cycle; reads have no side effect.
// [RQ15] Offsets are signed two's-complement values added to readings.
module hmo_monitor_status #(
   parameter longint unsigned WARN_COUNT = hmo_pkg::WARN_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   // Avalon-MM slave
   input wire logic [hmo_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic [1:0] o_avs_response,
   output logic o_avs_waitrequest,
   // Monitor sampling results
   input wire logic i_conv_done,
   input wire logic [7:0] i_cpu_temp_channel,
   input wire logic [7:0] i_system_temp_channel,
   input wire logic [7:0] i_aux_temp_channel,
   input wire hmo_pkg::hmo_temp_lim_s i_cpu_temp_lim,
   input wire hmo_pkg::hmo_temp_lim_s i_system_temp_lim,
   input wire hmo_pkg::hmo_temp_lim_s i_aux_temp_lim,
   input wire logic [3:0] i_fan_over_count,
   input wire logic [3:0] i_volt_out_of_range,
   input wire logic i_analog_in1_out_of_range,
   input wire logic i_chassis_intrusion,
   input wire logic i_intrusion_clear,
   input wire hmo_pkg::hmo_fan_ctl_s [hmo_pkg::NUM_WARN-1:0] i_fan_ctl,
   // Adjusted readings and flags
   output logic [7:0] o_cpu_temp_reading,
   output logic [7:0] o_aux_temp_reading,
   output logic [7:0] o_live_monitor_status_a,
   output logic [7:0] o_live_monitor_status_b,
   output logic o_irq
);
   import hmo_pkg::*;

   // Bus handshake states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } hmo_bus_e;

   // Bus handshake and register file state
   hmo_bus_e bus_state;
   logic [7:0] cpu_temp_offset;
   logic [7:0] aux_temp_offset;
   logic [7:0] live_monitor_status_a;
   logic [7:0] live_monitor_status_b;
   logic [15:0] event_status;
   logic [15:0] event_mask;

   // Intrusion synchroniser and latch
   logic intr_sync1;
   logic intr_sync2;
   logic intrusion_latched_flag;

   // Temperature alarms and fan-loop warnings
   logic cpu_temp_alarm;
   logic system_temp_alarm;
   logic aux_temp_alarm;
   logic [NUM_WARN-1:0] target_warning;
   logic [WARN_CNT_W-1:0] warn_cnt [NUM_WARN];

   // Corrected readings and next flag values
   logic [7:0] cpu_reading;
   logic [7:0] aux_reading;
   logic next_cpu_alarm;
   logic next_sys_alarm;
   logic next_aux_alarm;
   logic [7:0] next_status_a;
   logic [7:0] next_status_b;
   logic [15:0] new_events;
   logic [15:0] evt_clr;

   // Bus decode
   logic [7:0] idx;
   logic bus_req;
   logic wr_done;
   logic [31:0] rd_word;
   logic rd_hit;

   // Signed add with saturation to the 8-bit reading range
   function automatic logic [7:0] add_offset(input logic [7:0] value,
                                             input logic [7:0] offset);
      logic [8:0] sum;
      sum = {value[7], value} + {offset[7], offset};
      if (sum[8] != sum[7]) begin
         add_offset = sum[8] ? TEMP_MIN : TEMP_MAX;
      end else begin
         add_offset = sum[7:0];
      end
   endfunction : add_offset

   // Hysteresis comparator on signed readings
   function automatic logic temp_flag(input logic prev,
                                      input logic [7:0] reading,
                                      input hmo_temp_lim_s lim);
      if ($signed(reading) > $signed(lim.over)) begin
         temp_flag = 1'b1;
      end else if ($signed(reading) < $signed(lim.hyst)) begin
         temp_flag = 1'b0;
      end else begin
         temp_flag = prev;
      end
   endfunction : temp_flag

   // Offset-corrected readings
   always_comb begin
      cpu_reading = add_offset(i_cpu_temp_channel, cpu_temp_offset); // [RQ1] [RQ15]
      aux_reading = add_offset(i_aux_temp_channel, aux_temp_offset); // [RQ2] [RQ15]
   end

   // Readings registered onto the outputs
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cpu_temp_reading <= OFFSET_RST;
         o_aux_temp_reading <= OFFSET_RST;
      end else begin
         o_cpu_temp_reading <= cpu_reading; // [RQ1]
         o_aux_temp_reading <= aux_reading; // [RQ2]
      end
   end

   // Next temperature flags with hysteresis
   always_comb begin
      next_cpu_alarm = temp_flag(cpu_temp_alarm, cpu_reading,
                                 i_cpu_temp_lim); // [RQ5] [RQ6]
      next_sys_alarm = temp_flag(system_temp_alarm, i_system_temp_channel,
                                 i_system_temp_lim); // [RQ5] [RQ6]
      next_aux_alarm = temp_flag(aux_temp_alarm, aux_reading,
                                 i_aux_temp_lim); // [RQ5] [RQ6]
   end

   // Temperature flag state, advanced per conversion
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_temp_alarm <= 1'b0;
         system_temp_alarm <= 1'b0;
         aux_temp_alarm <= 1'b0;
      end else if (i_conv_done) begin
         cpu_temp_alarm <= next_cpu_alarm; // [RQ14]
         system_temp_alarm <= next_sys_alarm;
         aux_temp_alarm <= next_aux_alarm;
      end
   end

   // Intrusion pin synchroniser
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         intr_sync1 <= 1'b0;
         intr_sync2 <= 1'b0;
      end else begin
         intr_sync1 <= i_chassis_intrusion;
         intr_sync2 <= intr_sync1;
      end
   end

   // Intrusion latch; a new detection beats a clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         intrusion_latched_flag <= 1'b0;
      end else if (intr_sync2) begin
         intrusion_latched_flag <= 1'b1; // [RQ9]
      end else if (i_intrusion_clear) begin
         intrusion_latched_flag <= 1'b0;
      end
   end

   // Three-minute dwell timers of the fan-control loops
   for (genvar g = 0; g < NUM_WARN; g++) begin : g_warn
      logic dwell;
      assign dwell = i_fan_ctl[g].auto_mode && i_fan_ctl[g].full_speed &&
                     i_fan_ctl[g].over_target;
      // Counter holds at the limit; a drop of dwell clears both
      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            warn_cnt[g] <= '0;
            target_warning[g] <= 1'b0;
         end else if (!dwell) begin
            warn_cnt[g] <= '0;
            target_warning[g] <= 1'b0;
         end else if (warn_cnt[g] >= WARN_CNT_W'(WARN_COUNT - 1)) begin
            target_warning[g] <= 1'b1; // [RQ10] [RQ11] [RQ12]
         end else begin
            warn_cnt[g] <= warn_cnt[g] + WARN_CNT_W'(1);
         end
      end
   end

   // Assembly of both live status bytes
   always_comb begin
      next_status_a = STATUS_RST;
      next_status_a[SA_CPU_FAN0] = i_fan_over_count[FAN_CPU0]; // [RQ3]
      next_status_a[SA_SYS_FAN] = i_fan_over_count[FAN_SYS]; // [RQ3]
      next_status_a[SA_CPU_TEMP] = next_cpu_alarm; // [RQ5]
      next_status_a[SA_SYS_TEMP] = next_sys_alarm; // [RQ5]
      next_status_a[SA_VOLT_HI:0] = i_volt_out_of_range; // [RQ7]
      next_status_b = STATUS_RST;
      next_status_b[SB_CPU_FAN0_WARN] = target_warning[WARN_CPU0]; // [RQ11]
      next_status_b[SB_SYS_FAN_WARN] = target_warning[WARN_SYS]; // [RQ10]
      next_status_b[SB_AUX_TEMP] = next_aux_alarm; // [RQ5]
      next_status_b[SB_INTRUSION] = intrusion_latched_flag; // [RQ9]
      next_status_b[SB_AUX_FAN0] = i_fan_over_count[FAN_AUX0]; // [RQ4]
      next_status_b[SB_CPU_FAN1] = i_fan_over_count[FAN_CPU1]; // [RQ4]
      next_status_b[SB_CPU_FAN1_WARN] = target_warning[WARN_CPU1]; // [RQ12]
      next_status_b[SB_AIN1] = i_analog_in1_out_of_range; // [RQ8]
      new_events = {next_status_b, next_status_a} &
                   ~{live_monitor_status_b, live_monitor_status_a};
   end

   // Live status registers, refreshed only by conversions
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         live_monitor_status_a <= STATUS_RST;
         live_monitor_status_b <= STATUS_RST;
      end else if (i_conv_done) begin
         live_monitor_status_a <= next_status_a; // [RQ14]
         live_monitor_status_b <= next_status_b; // [RQ14] [RQ13]
      end
   end

   // Status mirrored onto the outputs
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_live_monitor_status_a <= STATUS_RST;
         o_live_monitor_status_b <= STATUS_RST;
      end else begin
         o_live_monitor_status_a <= live_monitor_status_a;
         o_live_monitor_status_b <= live_monitor_status_b;
      end
   end

   // Bus decode helpers
   assign idx = i_avs_address[IDX_LSB +: 8];
   assign bus_req = i_avs_read || i_avs_write;
   assign wr_done = (bus_state == BUS_ANSWER) && i_avs_write;

   // Handshake: one wait cycle, then waitrequest low for one edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bus_state <= BUS_IDLE;
         o_avs_waitrequest <= 1'b1;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (bus_req) begin
                  bus_state <= BUS_ANSWER;
                  o_avs_waitrequest <= 1'b0;
               end
            end
            BUS_ANSWER: begin
               bus_state <= BUS_IDLE;
               o_avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state <= BUS_IDLE;
               o_avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Read multiplexer; status reads have no side effect
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if (idx == IDX_CPU_OFFSET) begin
         rd_word[7:0] = cpu_temp_offset;
      end else if (idx == IDX_AUX_OFFSET) begin
         rd_word[7:0] = aux_temp_offset;
      end else if (idx == IDX_STATUS_A) begin
         rd_word[7:0] = live_monitor_status_a; // [RQ14]
      end else if (idx == IDX_STATUS_B) begin
         rd_word[7:0] = live_monitor_status_b;
      end else if (idx == IDX_EVT_STATUS) begin
         rd_word[15:0] = event_status;
      end else if (idx == IDX_EVT_MASK) begin
         rd_word[15:0] = event_mask;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read data and response, valid while waitrequest is low
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_avs_readdata <= 32'h0000_0000;
         o_avs_response <= RESP_OKAY;
      end else if (bus_state == BUS_IDLE && bus_req) begin
         o_avs_readdata <= i_avs_read ? rd_word : 32'h0000_0000;
         o_avs_response <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // Offset registers, written on the completing edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_temp_offset <= OFFSET_RST;
         aux_temp_offset <= OFFSET_RST;
      end else if (wr_done && i_avs_byteenable[0]) begin
         if (idx == IDX_CPU_OFFSET) begin
            cpu_temp_offset <= i_avs_writedata[7:0]; // [RQ1]
         end else if (idx == IDX_AUX_OFFSET) begin
            aux_temp_offset <= i_avs_writedata[7:0]; // [RQ2]
         end
      end
   end

   // Event mask, byte lanes 0 and 1
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         event_mask <= EVT_RST;
      end else if (wr_done && idx == IDX_EVT_MASK) begin
         if (i_avs_byteenable[0]) begin
            event_mask[7:0] <= i_avs_writedata[7:0];
         end
         if (i_avs_byteenable[1]) begin
            event_mask[15:8] <= i_avs_writedata[15:8];
         end
      end
   end

   // Write-one-to-clear mask of the event status, by byte lane
   always_comb begin
      evt_clr = EVT_RST;
      if (wr_done && idx == IDX_EVT_STATUS) begin
         evt_clr = i_avs_writedata[15:0] &
                   {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
      end
   end

   // Sticky events on rising flags; set beats write-one-to-clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         event_status <= EVT_RST;
      end else begin
         event_status <= (event_status & ~evt_clr) |
                         (i_conv_done ? new_events : EVT_RST);
      end
   end

   // Level interrupt from unmasked events
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(event_status & event_mask);
      end
   end
endmodule : hmo_monitor_status
`default_nettype wire

//--- verif/hmo_monitor_status_chk.sv
// Checker: bus timing and live status flag assertions of the monitor
`timescale 1ns/1ps
`default_nettype none
module hmo_monitor_status_chk (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [hmo_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic i_conv_done,
   input wire logic [3:0] i_fan_over_count,
   input wire logic [3:0] i_volt_out_of_range,
   input wire logic i_analog_in1_out_of_range,
   input wire hmo_pkg::hmo_fan_ctl_s [hmo_pkg::NUM_WARN-1:0] i_fan_ctl,
   input wire logic [31:0] o_avs_readdata,
   input wire logic [1:0] o_avs_response,
   input wire logic o_avs_waitrequest,
   input wire logic [7:0] o_live_monitor_status_a,
   input wire logic [7:0] o_live_monitor_status_b
);
   import hmo_pkg::*;
   logic [7:0] idx;
   logic mapped;
   logic stat;
   // Index decode of the byte address
   assign idx = i_avs_address[9:2];
   assign stat = (idx == IDX_STATUS_A) || (idx == IDX_STATUS_B);
   assign mapped = stat || idx inside {IDX_CPU_OFFSET, IDX_AUX_OFFSET,
                                       IDX_EVT_STATUS, IDX_EVT_MASK};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   chk_ack_one_cycle: assert property (
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer held longer than one cycle");
   chk_answer_bound: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest
      |-> ##[1:2] !o_avs_waitrequest) else $error("no answer");
   chk_status_lanes: assert property (
      !o_avs_waitrequest && i_avs_read && stat
      |-> o_avs_readdata[31:8] == 24'h0 && o_avs_response == RESP_OKAY)
      else $error("bad status read");
   chk_unmapped_error: assert property (
      !o_avs_waitrequest && (i_avs_read || i_avs_write) && !mapped
      |-> o_avs_response == RESP_SLVERR
          && (i_avs_write || o_avs_readdata == 32'h0))
      else $error("unmapped index not refused");
   chk_status_hold: assert property (
      $changed(o_live_monitor_status_a) || $changed(o_live_monitor_status_b)
      |-> $past(i_conv_done) || $past(i_conv_done, 2))
      else $error("status moved without conversion");
   chk_volt_flags: assert property (
      i_conv_done |-> ##[1:2]
      o_live_monitor_status_a[3:0] == i_volt_out_of_range)
      else $error("voltage flags wrong");
   chk_fan_flags: assert property (
      i_conv_done |-> ##[1:2]
      {o_live_monitor_status_a[7:6], o_live_monitor_status_b[3:2]} ==
      {i_fan_over_count[0], i_fan_over_count[1], i_fan_over_count[2],
       i_fan_over_count[3]}) else $error("fan flags wrong");
   chk_ain1_flag: assert property (
      i_conv_done |-> ##[1:2]
      o_live_monitor_status_b[0] == i_analog_in1_out_of_range)
      else $error("analog input one flag wrong");
   chk_sys_warn_off: assert property (
      i_conv_done && i_fan_ctl[WARN_SYS] != 3'h7
      |-> ##[1:2] !o_live_monitor_status_b[6]) else $error("sys warn");
   chk_cpu0_warn_off: assert property (
      i_conv_done && i_fan_ctl[WARN_CPU0] != 3'h7
      |-> ##[1:2] !o_live_monitor_status_b[7]) else $error("cpu0 warn");
   chk_cpu1_warn_off: assert property (
      i_conv_done && i_fan_ctl[WARN_CPU1] != 3'h7
      |-> ##[1:2] !o_live_monitor_status_b[1]) else $error("cpu1 warn");
endmodule : hmo_monitor_status_chk

bind hmo_monitor_status hmo_monitor_status_chk u_chk (.i_clk, .i_nrst,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_conv_done,
   .i_fan_over_count, .i_volt_out_of_range, .i_analog_in1_out_of_range,
   .i_fan_ctl, .o_avs_readdata, .o_avs_response, .o_avs_waitrequest,
   .o_live_monitor_status_a, .o_live_monitor_status_b);
`default_nettype wire

//--- verif/tb_top.sv
// Testbench: random and corner stimulus for the monitor status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hmo_pkg::*;
   localparam int WC = 20;
   logic clk, nrst, rd, wr, conv, intr, iclr, ain1, wreq, irq;
   logic fc, fs, fa, fi;
   logic [9:0] adr;
   logic [31:0] wd, rdat, got, rnd;
   logic [1:0] resp, gr;
   logic [7:0] tc, ts, ta, oc, oa, rc, ra, sa, sb, ea, eb;
   logic [3:0] fan, volt;
   logic [2:0] ew;
   hmo_temp_lim_s lim;
   hmo_fan_ctl_s [NUM_WARN-1:0] fctl;
   int bad_count, cmp_count;
   logic [7:0] ct [6] = '{8'h7f, 8'h80, 8'h7f, 8'h29, 8'h20, 8'h1d};
   logic [7:0] co [6] = '{8'h7f, 8'h80, 8'h81, 8'h00, 8'h00, 8'h00};
   logic [7:0] ri [6] = '{8'h55, 8'h56, 8'h59, 8'h5a, 8'h60, 8'h61};

   hmo_monitor_status #(.WARN_COUNT(WC)) u_dut (
      .i_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdat), .o_avs_response(resp),
      .o_avs_waitrequest(wreq), .i_conv_done(conv),
      .i_cpu_temp_channel(tc), .i_system_temp_channel(ts),
      .i_aux_temp_channel(ta), .i_cpu_temp_lim(lim),
      .i_system_temp_lim(lim), .i_aux_temp_lim(lim),
      .i_fan_over_count(fan), .i_volt_out_of_range(volt),
      .i_analog_in1_out_of_range(ain1), .i_chassis_intrusion(intr),
      .i_intrusion_clear(iclr), .i_fan_ctl(fctl),
      .o_cpu_temp_reading(rc), .o_aux_temp_reading(ra),
      .o_live_monitor_status_a(sa), .o_live_monitor_status_b(sb),
      .o_irq(irq));

   // Next pseudo-random word
   function automatic logic [31:0] nx(logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction : nx
   // Saturating signed sum of reading and offset
   function automatic logic [7:0] sat(logic [7:0] a, logic [7:0] b);
      int s;
      s = int'($signed(a)) + int'($signed(b));
      return s > 127 ? 8'h7f : (s < -128 ? 8'h80 : 8'(s));
   endfunction : sat
   // Over limit sets, under hysteresis clears, between holds
   function automatic logic hy(logic f, logic [7:0] r);
      if ($signed(r) > $signed(lim.over)) return 1'b1;
      if ($signed(r) < $signed(lim.hyst)) return 1'b0;
      return f;
   endfunction : hy
   // Compare and count
   task automatic chk(input logic [39:0] g, input logic [39:0] e,
                      input string m);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= {i, 2'b00};
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0);
      got = rdat;
      gr = resp;
      rd <= 1'b0;
      wr <= 1'b0;
      chk(n, 2, "answer latency");
   endtask : bus
   // Conversion pulse, then compare readings and live flags
   task automatic cnv();
      repeat (3) @(posedge clk);
      conv <= 1'b1;
      @(posedge clk);
      conv <= 1'b0;
      fc = hy(fc, sat(tc, oc));
      fs = hy(fs, ts);
      fa = hy(fa, sat(ta, oa));
      ea = {fan[0], fan[1], fc, fs, volt};
      eb = {ew[1], ew[0], fa, fi, fan[2], fan[3], ew[2], ain1};
      repeat (3) @(posedge clk);
      chk({rc, ra}, {sat(tc, oc), sat(ta, oa)}, "readings");
      chk({sa, sb}, {ea, eb}, "live status");
   endtask : cnv
   // Verdict and end of run
   task automatic test_done();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done();
   end
   // Main sequence
   initial begin
      {nrst, rd, wr, conv, intr, iclr, ain1, fc, fs, fa, fi} = '0;
      adr = '0; wd = '0; tc = '0; ts = '0; ta = '0; oc = '0; oa = '0;
      fan = '0; volt = '0; ew = '0; fctl = '0; rnd = 32'h0b31;
      lim = '{over: 8'h28, hyst: 8'h1e};
      bad_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      foreach (ri[i]) begin
         bus(1'b0, ri[i], '0);
         chk({gr, got}, {RESP_OKAY, 32'h0}, "reset value");
      end
      bus(1'b1, 8'h57, 32'hff);
      bus(1'b0, 8'h57, '0);
      chk({gr, got}, {RESP_SLVERR, 32'h0}, "unmapped");
      $display("Test reset done");
      for (int i = 0; i < 40; i++) begin
         rnd = nx(rnd);
         oc = i < 6 ? co[i] : rnd[7:0];
         oa = i < 6 ? co[i] : rnd[15:8];
         bus(1'b1, IDX_CPU_OFFSET, {rnd[31:8], oc});
         bus(1'b1, IDX_AUX_OFFSET, {rnd[31:8], oa});
         bus(1'b0, IDX_CPU_OFFSET, '0);
         chk(got, oc, "cpu offset");
         bus(1'b0, IDX_AUX_OFFSET, '0);
         chk(got, oa, "aux offset");
         rnd = nx(rnd);
         tc <= i < 6 ? ct[i] : rnd[7:0];
         ts <= i < 6 ? ct[i] : rnd[15:8];
         ta <= i < 6 ? ct[i] : rnd[23:16];
         fan <= rnd[27:24];
         volt <= rnd[31:28];
         rnd = nx(rnd);
         ain1 <= rnd[9];
         fctl <= rnd[8:0] & 9'h1b6;
         cnv();
         bus(1'b1, IDX_STATUS_A, rnd);
         bus(1'b1, IDX_STATUS_B, ~rnd);
         bus(1'b0, IDX_STATUS_A, '0);
         chk(got, ea, "status a read");
         bus(1'b0, IDX_STATUS_B, '0);
         chk(got, eb, "status b read");
      end
      $display("Test random status done");
      bus(1'b1, IDX_EVT_STATUS, 32'hffff);
      bus(1'b1, IDX_EVT_MASK, 32'h1000);
      bus(1'b0, IDX_EVT_STATUS, '0);
      chk({got, irq}, 33'h0, "events cleared");
      @(posedge clk) intr <= 1'b1;
      repeat (3) @(posedge clk);
      intr <= 1'b0;
      fi = 1'b1;
      cnv();
      chk(irq, 1'b1, "irq on intrusion");
      cnv();
      bus(1'b1, IDX_EVT_STATUS, 32'h1000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0, "irq cleared");
      iclr <= 1'b1;
      @(posedge clk) iclr <= 1'b0;
      fi = 1'b0;
      cnv();
      $display("Test intrusion done");
      for (int k = 0; k < NUM_WARN; k++) begin
         fctl[k] <= 3'h6;
         repeat (WC + 5) @(posedge clk);
         cnv();
         fctl[k] <= 3'h7;
         cnv();
         repeat (WC) @(posedge clk);
         ew[k] = 1'b1;
         cnv();
         fctl[k] <= 3'h0;
         ew[k] = 1'b0;
         cnv();
      end
      $display("Test warnings done");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
